// [msc_pkg.sv]
// Purpose: shared constants and types for the module sideband control block
// Assumes: 25 MHz system clock
// Notes: memory map content is a small flop array; offsets below are local choices
package msc_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned INIT_TIME_MS = 2000;
  localparam int unsigned INIT_CYCLES = (INIT_TIME_MS * (CLK_HZ / 1000));
  localparam int unsigned RESET_MIN_CYCLES = 16;
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam int unsigned MAP_DEPTH = 16;
  localparam logic [3:0] STATUS_OFS = 4'h2;
  localparam logic [3:0] IRQ_FLAGS_OFS = 4'h3;
  localparam logic [3:0] CONTROL_OFS = 4'h4;
  localparam int unsigned NOT_READY_BIT = 0;
  localparam int unsigned FAULT_FLAG_BIT = 0;
  localparam int unsigned RESET_DONE_FLAG_BIT = 1;
  localparam int unsigned HIGH_POWER_EN_BIT = 0;
  localparam logic [7:0] STATUS_RESET = 8'h01;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  typedef struct packed {
    logic scl_in;
    logic sda_in;
  } msc_twi_in_t;
  typedef struct packed {
    logic sda_out;
    logic sda_oe;
  } msc_twi_out_t;
  typedef enum {
    MSC_IDLE, MSC_ADDR, MSC_ADDR_ACK, MSC_WR, MSC_WR_ACK, MSC_RD, MSC_RD_ACK
  } msc_twi_state_t;
endpackage

// [msc_twi_target.sv]
// Purpose: two-wire bus target with byte read and write strobes
// Assumes: scl and sda already synchronous to sys_clk
// Notes: first written byte is the register pointer
`timescale 1ns/1ps
module msc_twi_target (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire msc_pkg::msc_twi_in_t twi_in,
  output msc_pkg::msc_twi_out_t twi_out,
  output logic [7:0] wr_data,
  output logic wr_stb,
  output logic ptr_stb,
  output logic rd_stb,
  input wire logic [7:0] rd_data
);
  import msc_pkg::*;
  logic scl_q;
  logic sda_q;
  msc_twi_state_t state;
  logic [7:0] shift;
  logic [3:0] bitcnt;
  logic first;
  logic rw;
  wire scl_rise = twi_in.scl_in & ~scl_q;
  wire scl_fall = ~twi_in.scl_in & scl_q;
  wire start = scl_q & twi_in.scl_in & sda_q & ~twi_in.sda_in;
  wire stop = scl_q & twi_in.scl_in & ~sda_q & twi_in.sda_in;

  //////////////////////////////////////////////////////////////////////////////
  // edge history
  always_ff @(posedge sys_clk) begin
    scl_q <= sys_rst ? 1'b1 : twi_in.scl_in;
    sda_q <= sys_rst ? 1'b1 : twi_in.sda_in;
  end

  // deselect aborts the frame, so a shared bus sees no stray acknowledge
  always_ff @(posedge sys_clk) begin
    wr_stb <= 1'b0;
    ptr_stb <= 1'b0;
    rd_stb <= 1'b0;
    if (sys_rst || !enable || stop) begin
      state <= MSC_IDLE;
      twi_out <= '0;
      bitcnt <= '0;
      first <= 1'b0;
      rw <= 1'b0;
      shift <= '0;
      wr_data <= '0;
    end else if (start) begin
      state <= MSC_ADDR;
      twi_out <= '0;
      bitcnt <= '0;
    end else begin
      unique case (state)
        MSC_IDLE: ;
        MSC_ADDR, MSC_WR: begin
          if (scl_rise) begin
            shift <= {shift[6:0], twi_in.sda_in};
            bitcnt <= bitcnt + 4'h1;
          end
          if (scl_fall && bitcnt == 4'h8) begin
            bitcnt <= '0;
            if (state == MSC_ADDR) begin
              if (shift[7:1] == DEV_ADDR) begin
                rw <= shift[0];
                first <= 1'b1;
                twi_out <= '{sda_out: 1'b0, sda_oe: 1'b1};
                state <= MSC_ADDR_ACK;
              end else begin
                state <= MSC_IDLE;
              end
            end else begin
              wr_data <= shift;
              ptr_stb <= first;
              wr_stb <= ~first;
              first <= 1'b0;
              twi_out <= '{sda_out: 1'b0, sda_oe: 1'b1};
              state <= MSC_WR_ACK;
            end
          end
        end
        MSC_ADDR_ACK, MSC_WR_ACK: begin
          if (scl_fall) begin
            if (state == MSC_ADDR_ACK && rw) begin
              shift <= rd_data;
              rd_stb <= 1'b1;
              twi_out <= '{sda_out: rd_data[7], sda_oe: ~rd_data[7]};
              bitcnt <= 4'h1;
              state <= MSC_RD;
            end else begin
              twi_out <= '0;
              state <= MSC_WR;
            end
          end
        end
        MSC_RD: begin
          if (scl_fall) begin
            if (bitcnt == 4'h8) begin
              twi_out <= '0;
              state <= MSC_RD_ACK;
            end else begin
              twi_out <= '{sda_out: shift[7 - bitcnt[2:0]], sda_oe: ~shift[7 - bitcnt[2:0]]};
              bitcnt <= bitcnt + 4'h1;
            end
          end
        end
        MSC_RD_ACK: begin
          if (scl_rise && twi_in.sda_in) begin
            state <= MSC_IDLE;
          end else if (scl_fall) begin
            shift <= rd_data;
            rd_stb <= 1'b1;
            twi_out <= '{sda_out: rd_data[7], sda_oe: ~rd_data[7]};
            bitcnt <= 4'h1;
            state <= MSC_RD;
          end
        end
      endcase
    end
  end

  ack_needs_select_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    twi_out.sda_oe |-> $past(enable)) else $error("sda driven while deselected");
endmodule // msc_twi_target

// [msc_sideband.sv]
// Purpose: sideband control of a pluggable four-lane module
// Assumes: all pins synchronous to sys_clk; open-drain scl and sda split in three signals, interrupt in two
// Notes: memory map is a small flop array behind the two-wire target
//
// Operation
// - answer bus only while select low
// - filtered long reset low restores defaults
// - completion pulls interrupt, clears not-ready
// - power-up posts completion without reset pulse
// - low-power select caps power
// - presence line tied low when inserted
// - interrupt low on fault or completion flag
// - interrupt only pulled low or released
// - fully functional within 2000 ms
`timescale 1ns/1ps
module msc_sideband #(
  parameter int unsigned INIT_CYC = msc_pkg::INIT_CYCLES,
  parameter int unsigned RST_MIN = msc_pkg::RESET_MIN_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic low_power_select,
  input wire logic fault_event,
  input wire msc_pkg::msc_twi_in_t twi_in,
  output msc_pkg::msc_twi_out_t twi_out,
  output logic scl_out,
  output logic scl_oe,
  output logic module_present_n,
  output logic interrupt_n_out,
  output logic interrupt_n_oe,
  output logic high_power_allowed,
  output logic init_done
);
  import msc_pkg::*;

  // refuse timings that the counters cannot serve
  if (INIT_CYC < 2 || RST_MIN < 1) begin : g_bad_timing
    $error("msc_sideband: bad timing parameters");
  end

  logic [7:0] map [MAP_DEPTH];
  logic [3:0] ptr;
  logic [31:0] init_cnt;
  logic [31:0] low_cnt;
  logic soft_reset;
  logic initializing;
  logic irq;
  logic sel;
  logic [7:0] wr_data;
  logic wr_stb;
  logic ptr_stb;
  logic rd_stb;
  msc_twi_out_t tw;

  //////////////////////////////////////////////////////////////////////////////
  // bus target, held idle unless selected
  always_ff @(posedge sys_clk) begin
    sel <= sys_rst ? 1'b0 : (~module_select_n & ~initializing);
  end

  msc_twi_target u_twi (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst | soft_reset),
    .enable(sel),
    .twi_in(twi_in),
    .twi_out(tw),
    .wr_data(wr_data),
    .wr_stb(wr_stb),
    .ptr_stb(ptr_stb),
    .rd_stb(rd_stb),
    .rd_data(map[ptr])
  );

  // registered copy so the top outputs come from flops; adds one cycle of sda lag
  always_ff @(posedge sys_clk) begin
    twi_out <= sys_rst ? '0 : (sel ? tw : '0);
    scl_out <= 1'b0;
    scl_oe <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // reset filter: only a low held longer than RST_MIN cycles counts
  always_ff @(posedge sys_clk) begin
    if (sys_rst || module_reset_n) begin
      low_cnt <= '0;
      soft_reset <= 1'b0;
    end else if (low_cnt < RST_MIN) begin
      // saturates at RST_MIN, so a long hold cannot wrap the count
      low_cnt <= low_cnt + 32'h1;
    end else begin
      soft_reset <= 1'b1;
    end
  end

  // init timer runs after power-up and after each accepted reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst || soft_reset) begin
      init_cnt <= '0;
      initializing <= 1'b1;
    end else if (initializing) begin
      if (init_cnt == INIT_CYC - 1) begin
        initializing <= 1'b0;
      end
      init_cnt <= init_cnt + 32'h1;
    end
  end

  // map decode shared by the write paths
  function automatic logic map_hit(input logic [3:0] at, input logic [3:0] ofs);
    return at == ofs;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // memory map; hardware sets win over host clears
  always_ff @(posedge sys_clk) begin
    if (sys_rst || soft_reset) begin
      for (int i = 0; i < MAP_DEPTH; i++) begin
        map[i] <= 8'h00;
      end
      map[STATUS_OFS] <= STATUS_RESET;
      map[CONTROL_OFS] <= CONTROL_RESET;
      ptr <= '0;
    end else begin
      if (ptr_stb) begin
        ptr <= wr_data[3:0];
      end else if (wr_stb || rd_stb) begin
        // pointer wraps at the map end, so long reads roll over to offset 0
        ptr <= ptr + 4'h1;
      end
      if (wr_stb && map_hit(ptr, CONTROL_OFS)) begin
        map[CONTROL_OFS] <= wr_data;
      end
      if (wr_stb && map_hit(ptr, IRQ_FLAGS_OFS)) begin
        map[IRQ_FLAGS_OFS] <= map[IRQ_FLAGS_OFS] & ~wr_data; // write one to clear
      end
      if (initializing && init_cnt == INIT_CYC - 1) begin
        map[STATUS_OFS][NOT_READY_BIT] <= 1'b0;
        map[IRQ_FLAGS_OFS][RESET_DONE_FLAG_BIT] <= 1'b1;
      end
      if (fault_event) begin
        map[IRQ_FLAGS_OFS][FAULT_FLAG_BIT] <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt and level pins
  always_ff @(posedge sys_clk) begin
    irq <= sys_rst ? 1'b0 : (map[IRQ_FLAGS_OFS] != 8'h00);
    // presence and interrupt data are constant lows; only the enable moves
    interrupt_n_out <= 1'b0;
    interrupt_n_oe <= sys_rst ? 1'b0 : irq;
    module_present_n <= 1'b0;
    init_done <= sys_rst ? 1'b0 : ~initializing;
  end

  // high power only when host allows it by pin and by control bit
  always_ff @(posedge sys_clk) begin
    high_power_allowed <= sys_rst ? 1'b0 :
      (~low_power_select & map[CONTROL_OFS][HIGH_POWER_EN_BIT] & ~initializing);
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  done_irq_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(initializing) |-> ##2 interrupt_n_oe) else $error("no completion interrupt");
  not_ready_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(initializing) |-> map[STATUS_OFS][NOT_READY_BIT] == 1'b0) else $error("not-ready stuck");
  reset_filter_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    soft_reset |-> !$past(module_reset_n) && low_cnt >= RST_MIN) else $error("short pulse reset");
  reset_default_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    soft_reset |=> map[CONTROL_OFS] == CONTROL_RESET && initializing) else $error("no default");
  low_power_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    low_power_select |=> !high_power_allowed) else $error("power cap ignored");
  deselect_quiet_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    module_select_n [*3] |-> !twi_out.sda_oe) else $error("answered while deselected");
  present_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !module_present_n && !interrupt_n_out) else $error("pin driven high");
  fault_irq_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    fault_event && !soft_reset |-> ##3 interrupt_n_oe) else $error("fault not signalled");
  init_bound_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(init_done) |-> $past(init_cnt) == INIT_CYC) else $error("init done early");

  // bus stays quiet through init; map writes land where the pointer says
  init_quiet_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    initializing [*3] |-> !twi_out.sda_oe) else $error("answered during init");
  select_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    module_select_n |=> !sel) else $error("select gate open");
  ptr_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wr_stb || rd_stb) && !soft_reset |=> ptr == $past(ptr) + 4'h1) else $error("pointer not stepped");
  ptr_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ptr_stb && !soft_reset |=> ptr == $past(wr_data[3:0])) else $error("pointer not loaded");
  ctrl_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_stb && map_hit(ptr, CONTROL_OFS) && !soft_reset |=> map[CONTROL_OFS] == $past(wr_data))
    else $error("control write lost");

  // reset filter and init timing as seen at low_cnt, the status map and init_done
  low_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !module_reset_n |=> low_cnt == $past(low_cnt) + 32'h1 || low_cnt == RST_MIN) else $error("low count slip");
  reset_quiet_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    soft_reset |=> ##1 !init_done) else $error("init done through reset");
  not_ready_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    initializing |-> map[STATUS_OFS][NOT_READY_BIT]) else $error("ready during init");

  // interrupt pin follows the flags two flops later; set beats clear
  irq_follows_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    interrupt_n_oe == ($past(map[IRQ_FLAGS_OFS], 2) != 8'h00)) else $error("interrupt off flags");
  fault_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    fault_event && !soft_reset |=> map[IRQ_FLAGS_OFS][FAULT_FLAG_BIT]) else $error("fault flag lost");
  power_enable_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !low_power_select && map[CONTROL_OFS][HIGH_POWER_EN_BIT] && !initializing |=> high_power_allowed)
    else $error("high power withheld");

  init_c: cover property (@(posedge sys_clk) $fell(initializing));
  rst_c: cover property (@(posedge sys_clk) soft_reset);
  wr_c: cover property (@(posedge sys_clk) wr_stb);
  rd_c: cover property (@(posedge sys_clk) rd_stb);
  flt_c: cover property (@(posedge sys_clk) fault_event);
endmodule // msc_sideband

// [msc_host_model.sv]
// Purpose: host board controller driving the two-wire bus and watching the interrupt line
// Assumes: pull-ups on scl, sda and interrupt line; quarter bit of five clocks
// Notes: open-drain wires resolved here from every party's enables
`timescale 1ns/1ps
module msc_host_model (
  input wire logic sys_clk,
  input wire msc_pkg::msc_twi_out_t twi_out,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic interrupt_n_out,
  input wire logic interrupt_n_oe,
  output msc_pkg::msc_twi_in_t twi_in,
  output logic irq_line
);
  import msc_pkg::*;
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // released wires float to the pull-up level, never hold the last value
  assign twi_in = {!(scl_low || (scl_oe && !scl_out)), !(sda_low || (twi_out.sda_oe && !twi_out.sda_out))};
  assign irq_line = !(interrupt_n_oe && !interrupt_n_out); // host pull-up
  ////////////////////////////////////////////////////////////////////////////////
  // bit timing: data moves only while scl is low, clock stands high when idle
  task automatic hold();
    repeat (5) @(negedge sys_clk);
  endtask
  task automatic start();
    sda_low = 1'b0;
    hold();
    scl_low = 1'b0;
    hold();
    sda_low = 1'b1;
    hold();
    scl_low = 1'b1;
    hold();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    hold();
    scl_low = 1'b0;
    hold();
    sda_low = 1'b0;
    hold();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    hold();
    scl_low = 1'b0;
    hold();
    r = twi_in.sda_in;
    hold();
    scl_low = 1'b1;
    hold();
  endtask
  // one byte plus acknowledge slot; ack low means the other side acknowledged
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack_in, ack);
  endtask
  task automatic write_reg(input logic [3:0] ptr, input logic [7:0] data, output logic ack);
    logic [7:0] q;
    logic a;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, q, ack);
    if (ack === 1'b0) begin
      xfer({4'h0, ptr}, 1'b1, q, a);
      xfer(data, 1'b1, q, a);
    end
    stop();
  endtask
  // two consecutive bytes, second one refused to end the read
  task automatic read_regs(input logic [3:0] ptr, output logic [15:0] d);
    logic [7:0] q;
    logic a;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, q, a);
    xfer({4'h0, ptr}, 1'b1, q, a);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, q, a);
    xfer(8'hFF, 1'b0, d[15:8], a);
    xfer(8'hFF, 1'b1, d[7:0], a);
    stop();
  endtask
endmodule // msc_host_model

// [msc_sideband_tb.sv]
// Purpose: self-checking bench for the sideband control block
// Assumes: init timer shortened to 400 cycles
// Notes: the bench owns this module's select line alone
`timescale 1ns/1ps
module msc_sideband_tb;
  import msc_pkg::*;
  logic sys_clk, sys_rst, module_select_n, module_reset_n, low_power_select, fault_event;
  msc_twi_in_t twi_in;
  msc_twi_out_t twi_out;
  logic scl_out, scl_oe, module_present_n, interrupt_n_out, interrupt_n_oe;
  logic high_power_allowed, init_done, irq_line, ack;
  logic [15:0] rd;
  int miscompares = 0;
  int cmp_count = 0;
  msc_sideband #(.INIT_CYC(400), .RST_MIN(16)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .module_select_n(module_select_n), .module_reset_n(module_reset_n), .low_power_select(low_power_select),
    .fault_event(fault_event), .twi_in(twi_in), .twi_out(twi_out), .scl_out(scl_out), .scl_oe(scl_oe),
    .module_present_n(module_present_n), .interrupt_n_out(interrupt_n_out), .interrupt_n_oe(interrupt_n_oe),
    .high_power_allowed(high_power_allowed), .init_done(init_done));
  msc_host_model i_host (.sys_clk(sys_clk), .twi_out(twi_out), .scl_out(scl_out), .scl_oe(scl_oe),
    .interrupt_n_out(interrupt_n_out), .interrupt_n_oe(interrupt_n_oe), .twi_in(twi_in), .irq_line(irq_line));
  ////////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog: the whole sequence needs about 7000 cycles
  initial begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence; inputs move on falling edges only
  initial begin
    sys_rst = 1'b1;
    module_select_n = 1'b0; // own select line
    module_reset_n = 1'b1;
    low_power_select = 1'b0;
    fault_event = 1'b0;
    tick(12);
    sys_rst = 1'b0;
    i_host.write_reg(4'h4, 8'h01, ack);
    check("ack during init", ack, 1);
    check("present", module_present_n, 0);
    check("no clock stretch", {scl_oe, scl_out}, 0);
    check("init early", init_done, 0);
    for (int i = 0; i < 600 && init_done !== 1'b1; i++) tick(1);
    tick(4);
    check("init done", init_done, 1);
    check("irq at power-up", irq_line, 0);
    i_host.read_regs(4'h2, rd); // status trusted only after completion
    check("status and flags", rd, 16'h0002);
    i_host.write_reg(4'h3, 8'h02, ack);
    tick(4);
    check("irq released", irq_line, 1);
    $display("test power-up done");
    module_select_n = 1'b1;
    i_host.write_reg(4'h4, 8'h01, ack);
    tick(4);
    check("ack deselected", ack, 1);
    check("power deselected", high_power_allowed, 0);
    module_select_n = 1'b0;
    i_host.write_reg(4'h4, 8'h01, ack);
    tick(4);
    check("ack selected", ack, 0);
    check("high power", high_power_allowed, 1);
    low_power_select = 1'b1;
    tick(4);
    check("power capped", high_power_allowed, 0);
    low_power_select = 1'b0;
    i_host.read_regs(4'h3, rd);
    check("flags and control", rd, 16'h0001);
    $display("test select and power done");
    fault_event = 1'b1;
    tick(1);
    fault_event = 1'b0;
    tick(4);
    check("irq on fault", irq_line, 0);
    i_host.read_regs(4'h3, rd);
    check("fault source", rd, 16'h0101);
    i_host.write_reg(4'h3, 8'h01, ack);
    tick(4);
    check("fault cleared", irq_line, 1);
    $display("test fault done");
    module_reset_n = 1'b0;
    tick(8);
    module_reset_n = 1'b1;
    tick(4);
    check("short reset", high_power_allowed, 1);
    module_reset_n = 1'b0;
    tick(40);
    module_reset_n = 1'b1;
    tick(600);
    check("reinit", init_done, 1);
    check("control default", high_power_allowed, 0);
    check("irq on completion", irq_line, 0);
    i_host.read_regs(4'h2, rd);
    check("status after reset", rd, 16'h0002);
    $display("test module reset done");
    test_done();
  end
endmodule // msc_sideband_tb
